/* File: design/arp_pkg.sv */
package arp_pkg;

   // ----------------------------------------------------------------
   // widths and timing
   // ----------------------------------------------------------------
   localparam int RES_W = 16;
   localparam int CLK_MHZ = 200;
   localparam int CONV_TIME_NS = 1000;
   localparam logic [7:0] CONV_CYC = 8'((CONV_TIME_NS * CLK_MHZ + 999) / 1000);
   localparam int CNV_LOW_NS = 20;
   localparam logic [7:0] CNV_LOW_CYC = 8'((CNV_LOW_NS * CLK_MHZ + 999) / 1000);
   localparam int SLV_SCLK_MHZ = 20;
   localparam logic [7:0] SLV_HALF_CYC = 8'(CLK_MHZ / (2 * SLV_SCLK_MHZ));
   localparam logic [7:0] PAR_WAIT_CYC = 8'h08;
   localparam logic [2:0] MS_DIV = 3'h2;
   localparam logic [4:0] N_BITS = 5'h10;

   // ----------------------------------------------------------------
   // controller register map
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STAT = 12'h004;
   localparam logic [11:0] ADDR_DATA = 12'h008;
   localparam int CTRL_START = 0;
   localparam int CTRL_SER = 1;
   localparam int CTRL_SWAP = 2;
   localparam int CTRL_EXT = 3;
   localparam int CTRL_RDC = 4;
   localparam int CTRL_INV = 5;
   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_ERR = 2;

   // controller sequence states
   typedef enum logic [5:0] {
      H_IDLE = 6'h01,
      H_CNV = 6'h02,
      H_BUSYW = 6'h04,
      H_WAITLO = 6'h08,
      H_XFER = 6'h10,
      H_DONE = 6'h20
   } arp_hst_t;

   // byte lane order of the parallel bus
   function automatic logic [15:0] arp_lanes(input logic [15:0] w, input logic swap);
      arp_lanes = swap ? {w[7:0], w[15:8]} : w;
   endfunction : arp_lanes

endpackage : arp_pkg

/* File: design/arp_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface arp_link_if;
   // strobes and straps from the controller
   logic convert_start_n;
   logic cs_n;
   logic rd_n;
   logic interface_select;
   logic byte_order_select;
   logic clock_source_select;
   logic read_mode_chain_input;
   logic clock_invert;
   // converter side drivers
   logic busy;
   logic [15:0] d_o;
   logic d_oe_n;
   logic serial_data_out_o;
   logic sync_o;
   logic sd_oe_n;
   logic sclk_dev_o;
   logic sclk_dev_oe_n;
   logic late_read_flag;
   // controller side clock driver
   logic sclk_host_o;
   logic sclk_host_oe_n;
   // resolved wires
   wire [15:0] d_bus;
   wire serial_data_out;
   wire frame_sync;
   wire sclk;

   // released lines settle at their pull-down level
   assign d_bus = d_oe_n ? 16'h0000 : d_o;
   assign serial_data_out = sd_oe_n ? 1'b0 : serial_data_out_o;
   assign frame_sync = sd_oe_n ? 1'b0 : sync_o;
   assign sclk = !sclk_dev_oe_n ? sclk_dev_o : (!sclk_host_oe_n ? sclk_host_o : 1'b0);

   modport device (
      input convert_start_n, cs_n, rd_n, interface_select, byte_order_select,
      input clock_source_select, read_mode_chain_input, clock_invert, sclk,
      output busy, d_o, d_oe_n, serial_data_out_o, sync_o, sd_oe_n, sclk_dev_o, sclk_dev_oe_n, late_read_flag
   );
   modport host (
      output convert_start_n, cs_n, rd_n, interface_select, byte_order_select,
      output clock_source_select, read_mode_chain_input, clock_invert, sclk_host_o, sclk_host_oe_n,
      input busy, d_bus, serial_data_out, frame_sync, late_read_flag, sclk
   );
endinterface : arp_link_if
`default_nettype wire

/* File: design/arp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module arp_sync #(
   parameter int W = 1
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic [W-1:0] d_in, // asynchronous inputs
   output logic [W-1:0] q_out // synchronised copies
);
   logic [W-1:0] meta_r;

   // two flops per bit, first stage read only by the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         q_out <= '0;
      end else begin
         meta_r <= d_in;
         q_out <= meta_r;
      end
   end
endmodule : arp_sync
`default_nettype wire

/* File: design/arp_device.sv */
`timescale 1ns/1ps
`default_nettype none
module arp_device (
   input wire logic pclk, // system clock, 200 MHz
   input wire logic presetn, // async reset, active low
   arp_link_if.device link, // converter pins
   input wire logic [15:0] sample_in, // value taken at conversion start
   output logic [15:0] last_result, // most recent conversion result
   output logic conv_done // pulse: conversion finished
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [8:0] pin_s;

   arp_sync #(.W(9)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      // active-low pins enter inverted, so reset reads as idle and no false start follows
      .d_in({~link.convert_start_n, ~link.cs_n, ~link.rd_n, link.sclk, link.read_mode_chain_input,
             link.interface_select, link.byte_order_select, link.clock_source_select, link.clock_invert}),
      .q_out(pin_s)
   );

   wire cnv_s = ~pin_s[8];
   wire cs_s = ~pin_s[7];
   wire rd_s = ~pin_s[6];
   wire sclk_s = pin_s[5];
   wire rmc_s = pin_s[4];
   wire ser_s = pin_s[3];
   wire swap_s = pin_s[2];
   wire ext_s = pin_s[1];
   wire inv_s = pin_s[0];

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic cnv_prev_r;
   logic sclk_prev_r;
   logic [7:0] conv_cnt_r;
   logic [15:0] held_r;
   logic [15:0] result_r;
   logic [15:0] shreg_r;
   logic [15:0] d_r;
   logic frame_r;
   logic hold_r;
   logic [2:0] div_r;
   logic [1:0] ph_r;
   logic [4:0] mbit_r;
   logic armed_r;
   logic chain_r;
   logic [4:0] rd_cnt_r;
   logic err_r;
   logic done_r;

   // ----------------------------------------------------------------
   // mode and event decode
   // ----------------------------------------------------------------
   wire master = ser_s & ~ext_s;
   wire slave = ser_s & ext_s;
   wire rdc = rmc_s;
   wire converting = conv_cnt_r != 8'h00;
   wire busy = converting | hold_r;
   wire cnv_fall = cnv_prev_r & ~cnv_s;
   wire start = cnv_fall & ~busy;
   wire conv_end = conv_cnt_r == 8'h01;

   // serial word load points
   wire load_m = master & (rdc ? start : conv_end);
   wire load_s = slave & (conv_end | (start & cs_s));
   wire load = load_m | load_s;
   wire [15:0] load_val = conv_end ? held_r : result_r;

   // master clock phases: data moves at phase 0, clock high in 1 and 2
   localparam logic [2:0] MS_DIV_M1 = arp_pkg::MS_DIV - 3'h1;
   localparam logic [4:0] N_BITS_M1 = arp_pkg::N_BITS - 5'h01;
   wire tick = frame_r & (div_r == MS_DIV_M1);
   wire m_shift = tick & (ph_r == 2'h3);
   wire frame_end = m_shift & (mbit_r == N_BITS_M1);
   wire m_high = frame_r & ((ph_r == 2'h1) | (ph_r == 2'h2));

   // slave clock edges, counted only while selected
   wire s_rise = ~sclk_prev_r & sclk_s & ~cs_s;
   wire s_fall = sclk_prev_r & ~sclk_s & ~cs_s;
   wire s_shift = slave & s_fall & armed_r;
   wire chain_in = slave & ~converting & chain_r;
   wire shift = m_shift | s_shift;
   wire rd_busy = (rd_cnt_r != 5'h00) & (rd_cnt_r != arp_pkg::N_BITS);

   // ----------------------------------------------------------------
   // conversion timing
   // ----------------------------------------------------------------
   // falling start edge begins a fixed-length conversion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnv_prev_r <= 1'b1;
         conv_cnt_r <= 8'h00;
         held_r <= 16'h0000;
         result_r <= 16'h0000;
         done_r <= 1'b0;
      end else begin
         cnv_prev_r <= cnv_s;
         done_r <= conv_end;
         if (start) begin
            conv_cnt_r <= arp_pkg::CONV_CYC;
            held_r <= sample_in;
         end else if (converting) begin
            conv_cnt_r <= conv_cnt_r - 8'h01;
         end
         if (conv_end) begin
            result_r <= held_r;
         end
      end
   end

   // ----------------------------------------------------------------
   // master serial clock generator
   // ----------------------------------------------------------------
   // frame runs 16 clock periods, busy held in after-mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_r <= 1'b0;
         hold_r <= 1'b0;
         div_r <= 3'h0;
         ph_r <= 2'h0;
         mbit_r <= 5'h00;
      end else if (load_m) begin
         frame_r <= 1'b1;
         hold_r <= ~rdc;
         div_r <= 3'h0;
         ph_r <= 2'h0;
         mbit_r <= 5'h00;
      end else if (frame_r) begin
         div_r <= tick ? 3'h0 : div_r + 3'h1;
         if (tick) begin
            ph_r <= ph_r + 2'h1;
         end
         if (m_shift) begin
            mbit_r <= mbit_r + 5'h01;
         end
         if (frame_end) begin
            frame_r <= 1'b0;
            hold_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // slave clock tracking and late read detection
   // ----------------------------------------------------------------
   // a falling edge shifts only after a rising edge was seen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_prev_r <= 1'b0;
         armed_r <= 1'b0;
         chain_r <= 1'b0;
         rd_cnt_r <= 5'h00;
         err_r <= 1'b0;
      end else begin
         sclk_prev_r <= sclk_s;
         err_r <= conv_end & slave & rd_busy;
         if (load) begin
            armed_r <= 1'b0;
            rd_cnt_r <= 5'h00;
         end else if (s_rise) begin
            armed_r <= 1'b1;
            chain_r <= rmc_s;
            if (rd_cnt_r != arp_pkg::N_BITS) begin
               rd_cnt_r <= rd_cnt_r + 5'h01;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // output data
   // ----------------------------------------------------------------
   // serial word, MSB first, chain bit enters at the bottom
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shreg_r <= 16'h0000;
         d_r <= 16'h0000;
      end else begin
         d_r <= arp_pkg::arp_lanes(result_r, swap_s);
         if (load) begin
            shreg_r <= load_val;
         end else if (shift) begin
            shreg_r <= {shreg_r[14:0], chain_in};
         end
      end
   end

   // pin drivers, data, frame and clock floated unless selected and read; busy and late flag always driven
   wire out_off = cs_s | rd_s;
   assign link.d_oe_n = out_off | ser_s;
   assign link.sd_oe_n = out_off | ~ser_s;
   assign link.sclk_dev_oe_n = out_off | ~master;
   assign link.d_o = d_r;
   assign link.serial_data_out_o = shreg_r[15];
   assign link.sync_o = frame_r ^ inv_s;
   assign link.sclk_dev_o = m_high ^ inv_s;
   assign link.late_read_flag = err_r;
   assign link.busy = busy;

   // user side status
   assign last_result = result_r;
   assign conv_done = done_r;

endmodule : arp_device
`default_nettype wire

/* File: design/arp_host.sv */
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module arp_host (
   input wire logic pclk, // system clock, 200 MHz
   input wire logic presetn, // async reset, active low
   input wire logic [11:0] paddr, // apb address
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   arp_link_if.host link // converter pins
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [20:0] pin_s;

   arp_sync #(.W(21)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d_in({link.busy, link.serial_data_out, link.frame_sync, link.late_read_flag, link.sclk, link.d_bus}),
      .q_out(pin_s)
   );

   wire busy_s = pin_s[20];
   wire sdo_s = pin_s[19];
   wire sync_s = pin_s[18];
   wire err_s = pin_s[17];
   wire sclk_s = pin_s[16];
   wire [15:0] d_s = pin_s[15:0];

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   arp_pkg::arp_hst_t state_r, state_nxt;
   logic [5:0] ctrl_r;
   logic [7:0] cnt_r, cnt_nxt;
   logic [4:0] bits_r, bits_nxt;
   logic [15:0] sh_r, sh_nxt;
   logic sclk_r, sclk_nxt;
   logic cnv_n_r, cnv_n_nxt;
   logic csrd_n_r;
   logic mlvl_prev_r;
   logic [15:0] data_r;
   logic done_r;
   logic lerr_r;
   logic [31:0] prdata_r;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire sel_ctrl = paddr == arp_pkg::ADDR_CTRL;
   wire sel_stat = paddr == arp_pkg::ADDR_STAT;
   wire sel_data = paddr == arp_pkg::ADDR_DATA;
   wire mapped = sel_ctrl | sel_stat | sel_data;
   wire wr = psel & penable & pwrite & mapped;
   wire rd_setup = psel & ~penable & ~pwrite;
   wire idle = state_r == arp_pkg::H_IDLE;
   wire start_req = wr & sel_ctrl & pwdata[arp_pkg::CTRL_START] & idle & ~busy_s;
   wire clr = wr & sel_stat;
   wire [31:0] rd_mux = sel_ctrl ? {26'h0, ctrl_r} :
                        sel_stat ? {29'h0, lerr_r, done_r, busy_s} :
                        sel_data ? {16'h0, data_r} : 32'h0;

   // ----------------------------------------------------------------
   // mode decode and master clock sampling
   // ----------------------------------------------------------------
   wire par = ~ctrl_r[arp_pkg::CTRL_SER];
   wire m_mode = ~par & ~ctrl_r[arp_pkg::CTRL_EXT];
   wire s_mode = ~par & ctrl_r[arp_pkg::CTRL_EXT];
   wire rdc = ctrl_r[arp_pkg::CTRL_RDC];
   wire inv = ctrl_r[arp_pkg::CTRL_INV];
   wire mlvl = sclk_s ^ inv;
   wire waiting = (state_r == arp_pkg::H_BUSYW) | (state_r == arp_pkg::H_WAITLO) | (state_r == arp_pkg::H_XFER);
   wire m_cap = m_mode & waiting & ~mlvl_prev_r & mlvl & (sync_s ^ inv);
   wire done_set = (state_r == arp_pkg::H_DONE) & ~busy_s;
   wire [7:0] xfer_cnt = par ? arp_pkg::PAR_WAIT_CYC : arp_pkg::SLV_HALF_CYC;

   // ----------------------------------------------------------------
   // read sequence
   // ----------------------------------------------------------------
   // start pulse, wait for busy, then read by the selected method
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      bits_nxt = bits_r;
      sh_nxt = sh_r;
      sclk_nxt = sclk_r;
      cnv_n_nxt = cnv_n_r;
      if (m_cap) begin
         sh_nxt = {sh_r[14:0], sdo_s};
         bits_nxt = bits_r + 5'h01;
      end
      case (state_r)
         arp_pkg::H_IDLE: begin
            if (start_req) begin
               cnv_n_nxt = 1'b0;
               cnt_nxt = arp_pkg::CNV_LOW_CYC;
               bits_nxt = 5'h00;
               state_nxt = arp_pkg::H_CNV;
            end
         end
         arp_pkg::H_CNV: begin
            if (cnt_r == 8'h01) begin
               cnv_n_nxt = 1'b1;
               state_nxt = arp_pkg::H_BUSYW;
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         arp_pkg::H_BUSYW: begin
            cnt_nxt = xfer_cnt;
            if (busy_s) begin
               state_nxt = (m_mode | rdc) ? arp_pkg::H_XFER : arp_pkg::H_WAITLO;
            end
         end
         arp_pkg::H_WAITLO: begin
            cnt_nxt = xfer_cnt;
            if (!busy_s) begin
               state_nxt = arp_pkg::H_XFER;
            end
         end
         arp_pkg::H_XFER: begin
            if (m_mode) begin
               if (bits_r == arp_pkg::N_BITS) begin
                  state_nxt = arp_pkg::H_DONE;
               end
            end else if (cnt_r == 8'h01) begin
               if (par) begin
                  sh_nxt = arp_pkg::arp_lanes(d_s, ctrl_r[arp_pkg::CTRL_SWAP]);
                  state_nxt = arp_pkg::H_DONE;
               end else begin
                  cnt_nxt = arp_pkg::SLV_HALF_CYC;
                  sclk_nxt = ~sclk_r;
                  if (sclk_r) begin
                     sh_nxt = {sh_r[14:0], sdo_s};
                     bits_nxt = bits_r + 5'h01;
                     if (bits_r == 5'h0f) begin
                        state_nxt = arp_pkg::H_DONE;
                     end
                  end
               end
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         arp_pkg::H_DONE: begin
            if (!busy_s) begin
               state_nxt = arp_pkg::H_IDLE;
            end
         end
         default: state_nxt = arp_pkg::H_IDLE;
      endcase
   end

   // sequence registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= arp_pkg::H_IDLE;
         cnt_r <= 8'h00;
         bits_r <= 5'h00;
         sh_r <= 16'h0000;
         sclk_r <= 1'b0;
         cnv_n_r <= 1'b1;
         csrd_n_r <= 1'b1;
         mlvl_prev_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         bits_r <= bits_nxt;
         sh_r <= sh_nxt;
         sclk_r <= sclk_nxt;
         cnv_n_r <= cnv_n_nxt;
         // deselected while idle, so a mode change cannot glitch the frame signal
         csrd_n_r <= ~((m_mode & (state_nxt != arp_pkg::H_IDLE)) | (state_nxt == arp_pkg::H_XFER));
         mlvl_prev_r <= mlvl;
      end
   end

   // software registers, hardware set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= arp_pkg::CTRL_RST;
         data_r <= 16'h0000;
         done_r <= 1'b0;
         lerr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else begin
         if (wr & sel_ctrl & idle) begin
            ctrl_r <= {pwdata[5:1], 1'b0};
         end
         if (done_set) begin
            data_r <= sh_r;
         end
         done_r <= done_set | (done_r & ~(clr & pwdata[arp_pkg::STAT_DONE]));
         lerr_r <= err_s | (lerr_r & ~(clr & pwdata[arp_pkg::STAT_ERR]));
         if (rd_setup) begin
            prdata_r <= rd_mux;
         end
      end
   end

   // pin and bus drivers
   assign link.convert_start_n = cnv_n_r;
   assign link.cs_n = csrd_n_r;
   assign link.rd_n = csrd_n_r;
   assign link.interface_select = ctrl_r[arp_pkg::CTRL_SER];
   assign link.byte_order_select = ctrl_r[arp_pkg::CTRL_SWAP];
   assign link.clock_source_select = ctrl_r[arp_pkg::CTRL_EXT];
   assign link.read_mode_chain_input = rdc;
   assign link.clock_invert = inv;
   assign link.sclk_host_o = sclk_r;
   assign link.sclk_host_oe_n = ~s_mode;
   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

endmodule : arp_host
`default_nettype wire

/* File: verification/arp_link_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module arp_link_monitor (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic convert_start_n, // start strobe
   input wire logic cs_n, // chip select
   input wire logic rd_n, // read enable
   input wire logic interface_select, // serial when high
   input wire logic clock_source_select, // slave when high
   input wire logic read_mode_chain_input, // read mode
   input wire logic clock_invert, // master polarity
   input wire logic busy, // conversion busy
   input wire logic d_oe_n, // parallel enable
   input wire logic sd_oe_n, // serial enable
   input wire logic sclk_dev_oe_n, // device clock enable
   input wire logic late_read_flag, // late read pulse
   input wire logic serial_data_out, // serial data
   input wire logic frame_sync, // frame valid
   input wire logic sclk // resolved clock
);
   // ----------------------------------------------------------------
   // helper counters
   // ----------------------------------------------------------------
   logic [2:0] rcnt_r;
   logic [9:0] bcnt_r;
   logic [4:0] ecnt_r;
   logic sc_r;
   wire sc = sclk ^ clock_invert;
   wire mser = interface_select && !clock_source_select;
   wire mfr = mser && !sd_oe_n && (frame_sync ^ clock_invert);
   wire mafter = mser && !read_mode_chain_input;
   // cycles since reset, busy length, clock rises in a frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rcnt_r <= '0;
         bcnt_r <= '0;
         ecnt_r <= '0;
         sc_r <= 1'b0;
      end else begin
         rcnt_r <= (rcnt_r == 3'd7) ? rcnt_r : rcnt_r + 3'd1;
         bcnt_r <= busy ? bcnt_r + 10'd1 : 10'd0;
         ecnt_r <= !mfr ? 5'd0 : ecnt_r + 5'((sc && !sc_r) ? 1 : 0);
         sc_r <= sc;
      end
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_start;
      $fell(convert_start_n) && !busy && rcnt_r == 3'd7;
   endsequence
   sequence s_conv;
      busy [*8];
   endsequence
   a_busy_start: assert property (s_start |-> ##[2:4] s_conv)
      else $error("busy did not follow start");
   a_conv_len: assert property ($fell(busy) && !mafter |-> bcnt_r >= 10'd195 && bcnt_r <= 10'd205)
      else $error("conversion length wrong");
   a_busy_ext: assert property ($fell(busy) && mafter |-> bcnt_r >= 10'd300)
      else $error("busy ended before shifting");
   a_bit_count: assert property ($fell(mfr) |-> ecnt_r == 5'd16)
      else $error("frame clock count not 16");
   a_data_stable: assert property (mfr && $rose(sc) |-> $stable(serial_data_out))
      else $error("data moved at clock edge");
   a_master_clk: assert property (mfr |-> !sclk_dev_oe_n)
      else $error("master frame without clock drive");
   a_slave_clk: assert property (clock_source_select [*4] |-> sclk_dev_oe_n)
      else $error("device drives clock in slave mode");
   a_float_out: assert property (((cs_n || rd_n) [*4]) ##0 (rcnt_r == 3'd7) |-> d_oe_n && sd_oe_n)
      else $error("outputs driven while deselected");
   a_late_pulse: assert property (late_read_flag |-> clock_source_select && !$past(late_read_flag))
      else $error("late read flag misplaced");
endmodule : arp_link_monitor
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = '0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [15:0] sample_in = '0;
   logic [15:0] last_result;
   logic conv_done;
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   logic [15:0] q_rd[$];
   logic [15:0] q_cv[$];
   logic [15:0] q_sr[$];
   logic [15:0] sh = '0;
   logic fa_q = 1'b0;
   logic sc_q = 1'b0;
   logic [5:0] modes[8] = '{6'h00, 6'h04, 6'h10, 6'h02, 6'h22, 6'h12, 6'h0a, 6'h1a};
   // ----------------------------------------------------------------
   // design ends and checker
   // ----------------------------------------------------------------
   arp_link_if u_arp_link_if ();
   arp_device u_arp_device (.pclk(pclk), .presetn(presetn), .link(u_arp_link_if), .sample_in(sample_in),
      .last_result(last_result), .conv_done(conv_done));
   arp_host u_arp_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(u_arp_link_if));
   arp_link_monitor u_mon (.pclk(pclk), .presetn(presetn), .convert_start_n(u_arp_link_if.convert_start_n),
      .cs_n(u_arp_link_if.cs_n), .rd_n(u_arp_link_if.rd_n), .interface_select(u_arp_link_if.interface_select),
      .clock_source_select(u_arp_link_if.clock_source_select), .clock_invert(u_arp_link_if.clock_invert),
      .read_mode_chain_input(u_arp_link_if.read_mode_chain_input), .busy(u_arp_link_if.busy),
      .d_oe_n(u_arp_link_if.d_oe_n), .sd_oe_n(u_arp_link_if.sd_oe_n), .sclk(u_arp_link_if.sclk),
      .sclk_dev_oe_n(u_arp_link_if.sclk_dev_oe_n), .late_read_flag(u_arp_link_if.late_read_flag),
      .serial_data_out(u_arp_link_if.serial_data_out), .frame_sync(u_arp_link_if.frame_sync));
   wire sc = u_arp_link_if.sclk ^ u_arp_link_if.clock_invert;
   wire fa = (u_arp_link_if.sd_oe_n === 1'b0) && ((u_arp_link_if.frame_sync ^ u_arp_link_if.clock_invert) === 1'b1)
      && u_arp_link_if.interface_select && !u_arp_link_if.clock_source_select;
   // clock
   initial begin
      forever #2.5 pclk = !pclk;
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("FAIL %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // ----------------------------------------------------------------
   // output watchers and timeout
   // ----------------------------------------------------------------
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         wrap_up();
      end
      if (psel && penable) chk({31'h0, pslverr}, {31'h0, paddr > arp_pkg::ADDR_DATA});
      if (psel && penable && !pwrite && paddr == arp_pkg::ADDR_DATA) chk(prdata, {16'h0, q_rd.pop_front()});
      if (conv_done === 1'b1) chk({16'h0, last_result}, {16'h0, q_cv.pop_front()});
      fa_q <= fa;
      sc_q <= sc;
      if (fa && sc && !sc_q) sh <= {sh[14:0], u_arp_link_if.serial_data_out};
      if (fa_q && !fa) chk({16'h0, sh}, {16'h0, q_sr.pop_front()});
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] q;
      logic [15:0] prev;
      logic [15:0] s;
      logic [5:0] m;
      void'($urandom(32'h65ee));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(arp_pkg::ADDR_CTRL, 1'b0, 32'h0, q);
      chk(q, 32'h0);
      apb(arp_pkg::ADDR_STAT, 1'b0, 32'h0, q);
      chk(q, 32'h0);
      apb(12'h00c, 1'b0, 32'h0, q);
      chk(q, 32'h0);
      prev = '0;
      for (int i = 0; i < 16; i++) begin
         m = modes[i % 8];
         s = 16'($urandom());
         sample_in <= s;
         apb(arp_pkg::ADDR_CTRL, 1'b1, {26'h0, m}, q);
         apb(arp_pkg::ADDR_CTRL, 1'b1, {26'h0, m | 6'h01}, q);
         q_cv.push_back(s);
         if (m[1] && !m[3]) q_sr.push_back(m[4] ? prev : s);
         q = '0;
         while (q[arp_pkg::STAT_DONE] !== 1'b1) apb(arp_pkg::ADDR_STAT, 1'b0, 32'h0, q);
         chk({31'h0, q[arp_pkg::STAT_ERR]}, 32'h0);
         apb(arp_pkg::ADDR_STAT, 1'b1, 32'h6, q);
         q_rd.push_back(m[4] ? prev : s);
         apb(arp_pkg::ADDR_DATA, 1'b0, 32'h0, q);
         prev = s;
      end
      repeat (10) @(posedge pclk);
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
